// file: logic/tsi_defs.svh
`ifndef TSI_DEFS_SVH
`define TSI_DEFS_SVH
`define TSI_ADDR_BASE 7'h40
`define TSI_ADDR_MASK 7'h78
`define TSI_PINS_IDLE 6'h30
`define TSI_PTR_VSENSE 8'h00
`define TSI_PTR_TDIE 8'h01
`define TSI_VSENSE_RESET 16'h0000
`define TSI_TDIE_RESET 16'h0000
`define TSI_VSENSE_MAX 16'h7FFF
`define TSI_VSENSE_MIN 16'h8000
`define TSI_HS_CODE 7'h04
`define TSI_TDIE_PAD 2'h0
`define TSI_NV_PER_LSB_X100 15625
`define TSI_FS_UV 5120
`define TSI_FILT_LEN 2
`endif

// file: logic/tsi_pkg.sv
package tsi_pkg;
   typedef enum logic [2:0] {
      TSI_IDLE,
      TSI_RX,
      TSI_ACK,
      TSI_TX,
      TSI_TXACK
   } tsi_state_t;
   typedef enum logic [1:0] {
      TSI_PIN_LOW,
      TSI_PIN_HIGH,
      TSI_PIN_SDA,
      TSI_PIN_SCL
   } tsi_strap_t;
endpackage

// file: logic/tsi_sync.sv
`timescale 1ns/10ps
module tsi_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clock, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic [WIDTH-1:0] async_in, // pin levels
   output logic [WIDTH-1:0] sync_out // synchronised levels
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;
   if (WIDTH < 1) begin : g_width_check
      $error("tsi_sync width must be positive");
   end
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_q <= RESET_VAL;
         sync_q <= RESET_VAL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end
   assign sync_out = sync_q;
endmodule

// file: logic/tsi_slave.sv
`timescale 1ns/10ps
`include "tsi_defs.svh"
// Notes on behaviour
// - voltage result is 16-bit two's complement
// - voltage clips at 7FFF and 8000
// - one count is 156.25 nV
// - die temperature 14-bit, 1/32 C per count
// - temperature left aligned, low bits zero
// - target only, never drives clock
// - fast and high-speed bus rates supported
// - every byte shifted MSB first
// - select pins sampled each transaction
// - responds at 1000000 to 1000111
// - first written byte loads pointer
// - read returns register chosen by pointer
// - pointer unchanged across reads
// - upper byte first, then lower byte
// - pointer 00h is voltage, resets zero
// - high-speed code not acked, mode until stop
module tsi_slave
   import tsi_pkg::*;
#(
   parameter int VWIDTH = 24 // raw signed voltage sample width
) (
   input wire logic clock, // 200 MHz system clock
   input wire logic resetn, // async reset, active low
   input wire logic scl_in, // bus clock pin level
   input wire logic sda_in, // bus data pin level
   output logic sda_out, // data driven level, always low
   output logic sda_oe, // high while pulling data low
   input wire logic address_select_pin_0_in, // select pin 0 level
   input wire logic address_select_pin_0_oe_sda, // select pin 0 strapped to data
   input wire logic address_select_pin_0_oe_scl, // select pin 0 strapped to clock
   input wire logic address_select_pin_1, // select pin 1 level
   input wire logic signed [VWIDTH-1:0] vsense_raw, // raw sensor sample, 156.25 nV units
   input wire logic signed [13:0] tdie_raw, // die temperature, 1/32 C units
   input wire logic result_load, // one-cycle pulse, capture new results
   output logic [7:0] pointer, // current register pointer
   output logic hs_mode, // high-speed mode flag, set by the code, cleared on stop
   output logic [7:0] wr_data, // received register data byte
   output logic wr_valid, // one-cycle pulse per data byte written
   output logic wr_high // data byte is upper byte of word
);
   if (VWIDTH < 16) begin : g_vwidth_check
      $error("tsi_slave VWIDTH must be at least 16");
   end

   // bus lines reset to their idle high level so no false edge follows reset
   logic [5:0] pins_s;
   tsi_sync #(.WIDTH(6), .RESET_VAL(`TSI_PINS_IDLE)) u_sync (
      .clock(clock),
      .resetn(resetn),
      .async_in({scl_in, sda_in, address_select_pin_0_in, address_select_pin_1, address_select_pin_0_oe_sda,
                 address_select_pin_0_oe_scl}),
      .sync_out(pins_s)
   );
   wire scl_s = pins_s[5];
   wire sda_s = pins_s[4];

   // saturate wide raw sample into 16 bits instead of wrapping
   function automatic logic [15:0] clip_v(input logic signed [VWIDTH-1:0] v);
      if (v > $signed({{(VWIDTH-16){1'b0}}, `TSI_VSENSE_MAX}))
         clip_v = `TSI_VSENSE_MAX;
      else if (v < $signed({{(VWIDTH-16){1'b1}}, `TSI_VSENSE_MIN}))
         clip_v = `TSI_VSENSE_MIN;
      else
         clip_v = v[15:0];
   endfunction

   // decode the four-state strap of select pin 0 into the low address bits
   function automatic logic [6:0] decode_addr(input logic p0, input logic to_sda, input logic to_scl,
                                             input logic p1);
      tsi_strap_t s;
      s = to_sda ? TSI_PIN_SDA : (to_scl ? TSI_PIN_SCL : (p0 ? TSI_PIN_HIGH : TSI_PIN_LOW));
      decode_addr = `TSI_ADDR_BASE | {4'h0, p1, 2'(s)};
   endfunction

   // results registers
   logic [15:0] vsense_q, vsense_d, tdie_q, tdie_d;
   always_comb begin
      vsense_d = vsense_q;
      tdie_d = tdie_q;
      if (result_load) begin
         vsense_d = clip_v(vsense_raw);
         tdie_d = {tdie_raw, `TSI_TDIE_PAD};
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         vsense_q <= `TSI_VSENSE_RESET;
         tdie_q <= `TSI_TDIE_RESET;
      end else begin
         vsense_q <= vsense_d;
         tdie_q <= tdie_d;
      end
   end

   // bus edge and condition detection, on the second synchroniser stage only
   logic scl_p_q, sda_p_q;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end
   // the system clock oversamples 3.4 MHz by ~58x, so edge detection is clean
   wire scl_rise = scl_s & ~scl_p_q;
   wire scl_fall = ~scl_s & scl_p_q;
   wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

   tsi_state_t st_q, st_d;
   logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
   logic [3:0] bit_q, bit_d;
   logic [1:0] byte_q, byte_d; // 0 address, 1 pointer, 2+ data
   logic rd_q, rd_d, ack_q, ack_d, hs_q, hs_d, lo_q, lo_d;
   logic oe_q, oe_d, wv_q, wv_d, wh_q, wh_d;
   logic [7:0] wd_q, wd_d;
   logic [6:0] my_addr;
   logic [15:0] rd_word;

   always_comb begin
      // pins sampled afresh on every address byte
      my_addr = decode_addr(pins_s[3], pins_s[1], pins_s[0], pins_s[2]);
      rd_word = (ptr_q == `TSI_PTR_VSENSE) ? vsense_q :
                (ptr_q == `TSI_PTR_TDIE) ? tdie_q : 16'h0000;
   end

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      bit_d = bit_q;
      byte_d = byte_q;
      rd_d = rd_q;
      ack_d = ack_q;
      hs_d = hs_q;
      lo_d = lo_q;
      oe_d = oe_q;
      wv_d = 1'b0;
      wh_d = wh_q;
      wd_d = wd_q;
      if (stop_c) begin
         st_d = TSI_IDLE;
         oe_d = 1'b0;
         hs_d = 1'b0;
      end else if (start_c) begin
         st_d = TSI_RX;
         bit_d = 4'h0;
         byte_d = 2'h0;
         oe_d = 1'b0;
         lo_d = 1'b0;
      end else begin
         case (st_q)
            TSI_IDLE: begin
               oe_d = 1'b0;
            end
            TSI_RX: begin
               if (scl_rise) begin
                  sh_d = {sh_q[6:0], sda_s};
                  bit_d = bit_q + 4'h1;
               end else if (scl_fall && bit_q == 4'h8) begin
                  bit_d = 4'h0;
                  ack_d = 1'b0;
                  if (byte_q == 2'h0) begin
                     rd_d = sh_q[0];
                     if (sh_q[7:1] == `TSI_HS_CODE) begin
                        hs_d = 1'b1; // no ack, wait for the next start
                        st_d = TSI_IDLE;
                     end else if (sh_q[7:1] == my_addr) begin
                        ack_d = 1'b1;
                        st_d = TSI_ACK;
                     end else begin
                        st_d = TSI_IDLE;
                     end
                  end else begin
                     ack_d = 1'b1;
                     st_d = TSI_ACK;
                     if (byte_q == 2'h1) begin
                        ptr_d = sh_q;
                     end else begin
                        wd_d = sh_q;
                        wv_d = 1'b1;
                        wh_d = ~lo_q;
                        lo_d = ~lo_q;
                     end
                  end
                  oe_d = ack_d;
               end
            end
            TSI_ACK: begin
               if (scl_fall) begin
                  if (byte_q != 2'h3) byte_d = byte_q + 2'h1;
                  if (rd_q) begin
                     st_d = TSI_TX;
                     oe_d = ~rd_word[15];
                     sh_d = rd_word[15:8];
                     lo_d = 1'b0;
                  end else begin
                     st_d = TSI_RX;
                     oe_d = 1'b0;
                  end
               end
            end
            TSI_TX: begin
               if (scl_fall) begin
                  bit_d = bit_q + 4'h1;
                  if (bit_q == 4'h7) begin
                     oe_d = 1'b0;
                     st_d = TSI_TXACK;
                     bit_d = 4'h0;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     oe_d = ~sh_q[6];
                  end
               end
            end
            TSI_TXACK: begin
               if (scl_rise) begin
                  if (sda_s) begin
                     st_d = TSI_IDLE; // pointer kept
                  end else begin
                     lo_d = ~lo_q;
                  end
               end else if (scl_fall) begin
                  st_d = TSI_TX;
                  // after upper byte send lower; further bytes repeat the word
                  sh_d = lo_q ? rd_word[7:0] : rd_word[15:8];
                  oe_d = lo_q ? ~rd_word[7] : ~rd_word[15];
               end
            end
            default: st_d = TSI_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_q <= TSI_IDLE;
         sh_q <= 8'h00;
         ptr_q <= `TSI_PTR_VSENSE;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
         rd_q <= 1'b0;
         ack_q <= 1'b0;
         hs_q <= 1'b0;
         lo_q <= 1'b0;
         oe_q <= 1'b0;
         wv_q <= 1'b0;
         wh_q <= 1'b0;
         wd_q <= 8'h00;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         bit_q <= bit_d;
         byte_q <= byte_d;
         rd_q <= rd_d;
         ack_q <= ack_d;
         hs_q <= hs_d;
         lo_q <= lo_d;
         oe_q <= oe_d;
         wv_q <= wv_d;
         wh_q <= wh_d;
         wd_q <= wd_d;
      end
   end

   // open drain: only ever pull low, never drive the clock line
   assign sda_out = 1'b0;
   assign sda_oe = oe_q;
   assign pointer = ptr_q;
   assign hs_mode = hs_q;
   assign wr_data = wd_q;
   assign wr_valid = wv_q;
   assign wr_high = wh_q;

   property p_clip_high;
      @(posedge clock) disable iff (!resetn)
         result_load && vsense_raw > $signed({{(VWIDTH-16){1'b0}}, `TSI_VSENSE_MAX})
            |=> vsense_q == `TSI_VSENSE_MAX;
   endproperty
   a_clip_high: assert property (p_clip_high) else $error("voltage not clipped high");

   property p_clip_low;
      @(posedge clock) disable iff (!resetn)
         result_load && vsense_raw < $signed({{(VWIDTH-16){1'b1}}, `TSI_VSENSE_MIN})
            |=> vsense_q == `TSI_VSENSE_MIN;
   endproperty
   a_clip_low: assert property (p_clip_low) else $error("voltage not clipped low");

   property p_tdie_align;
      @(posedge clock) disable iff (!resetn)
         result_load |=> tdie_q[1:0] == 2'b00 && tdie_q[15:2] == $past(tdie_raw);
   endproperty
   a_tdie_align: assert property (p_tdie_align) else $error("temperature misaligned");

   property p_ptr_load;
      @(posedge clock) disable iff (!resetn)
         st_q == TSI_RX && scl_fall && bit_q == 4'h8 && byte_q == 2'h1 && !start_c && !stop_c
            |=> ptr_q == $past(sh_q) && sda_oe;
   endproperty
   a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

   property p_ptr_read;
      @(posedge clock) disable iff (!resetn)
         rd_q && st_q != TSI_IDLE |-> $stable(ptr_q);
   endproperty
   a_ptr_read: assert property (p_ptr_read) else $error("pointer changed in read");

   property p_hs_noack;
      @(posedge clock) disable iff (!resetn)
         st_q == TSI_RX && scl_fall && bit_q == 4'h8 && byte_q == 2'h0 && sh_q[7:1] == `TSI_HS_CODE
            && !start_c && !stop_c |=> !sda_oe && hs_mode;
   endproperty
   a_hs_noack: assert property (p_hs_noack) else $error("high-speed code handled wrongly");

   property p_hs_stop;
      @(posedge clock) disable iff (!resetn)
         stop_c |=> !hs_mode ##1 !hs_mode;
   endproperty
   a_hs_stop: assert property (p_hs_stop) else $error("high-speed not left on stop");

   property p_addr_nack;
      @(posedge clock) disable iff (!resetn)
         st_q == TSI_RX && scl_fall && bit_q == 4'h8 && byte_q == 2'h0 && sh_q[7:1] != my_addr
            && !start_c && !stop_c |=> !sda_oe [*2];
   endproperty
   a_addr_nack: assert property (p_addr_nack) else $error("acked foreign address");

   property p_addr_range;
      @(posedge clock) disable iff (!resetn)
         $rose(sda_oe) && st_q == TSI_ACK && byte_q == 2'h0 |-> (sh_q[7:1] & `TSI_ADDR_MASK) == `TSI_ADDR_BASE;
   endproperty
   a_addr_range: assert property (p_addr_range) else $error("address out of range");

   property p_tx_msb;
      @(posedge clock) disable iff (!resetn)
         st_q == TSI_ACK && rd_q && scl_fall && !start_c && !stop_c |=> sda_oe == ~$past(rd_word[15]);
   endproperty
   a_tx_msb: assert property (p_tx_msb) else $error("read did not start with upper MSB");
endmodule

// file: sim/tsi_master_model.sv
`timescale 1ns/10ps
module tsi_master_model (
   input wire logic clock, // system clock
   input wire logic sda, // resolved data line
   output logic scl, // bus clock, master only
   output logic sda_low, // high while pulling data low
   output logic [7:0] rx_byte, // last byte read
   output logic rx_stb // one-cycle pulse per byte read
);
   // half period in clocks: 250 gives fast mode, 30 high-speed
   int half = 250;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      rx_byte = 8'h00;
      rx_stb = 1'b0;
   end
   task automatic hw();
      repeat (half) @(posedge clock);
      #1;
   endtask
   // data moves a few cycles after the low edge so it never races the clock
   task automatic pulse(output logic s);
      hw();
      scl = 1'b1;
      hw();
      s = sda;
      scl = 1'b0;
      repeat (4) @(posedge clock);
      #1;
   endtask
   task automatic start();
      if (scl == 1'b0) begin
         sda_low = 1'b0;
         hw();
         scl = 1'b1;
      end
      hw();
      sda_low = 1'b1;
      hw();
      scl = 1'b0;
      repeat (4) @(posedge clock);
      #1;
   endtask
   // clock stands high after the stop, so it is still outside frames
   task automatic stop();
      sda_low = 1'b1;
      hw();
      scl = 1'b1;
      hw();
      sda_low = 1'b0;
      hw();
   endtask
   task automatic put_bit(input logic b);
      logic s;
      sda_low = !b;
      pulse(s);
   endtask
   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i]);
      end
      sda_low = 1'b0;
      pulse(s);
      ack = !s;
   endtask
   task automatic read_byte(input logic last, output logic [7:0] b);
      logic s;
      sda_low = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         pulse(s);
         b[i] = s;
      end
      rx_byte = b;
      rx_stb = 1'b1;
      @(posedge clock);
      #1;
      rx_stb = 1'b0;
      put_bit(last);
   endtask
endmodule

// file: sim/tsi_slave_tb.sv
`timescale 1ns/10ps
module tsi_slave_tb;
   import tsi_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic scl, sda_line, m_low, sda_out, sda_oe, pin1, result_load, hs_mode, wr_valid, wr_high, rx_stb;
   logic [7:0] pointer, wr_data, rx_byte;
   logic [8:0] e;
   logic signed [23:0] vsense;
   logic signed [13:0] tdie;
   logic signed [23:0] vtab [3] = '{24'h008000, 24'hFF7FFF, 24'h007FFF};
   tsi_strap_t strap;
   logic [7:0] rd_q [$];
   logic [8:0] wr_q [$];
   integer seed = 10299;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   always #2.5 clock = ~clock;
   assign sda_line = (m_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
   tsi_master_model u_mst (.clock(clock), .sda(sda_line), .scl(scl), .sda_low(m_low), .rx_byte(rx_byte),
      .rx_stb(rx_stb));
   tsi_slave u_dut (.clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .address_select_pin_0_in((strap == TSI_PIN_SDA) ? sda_line :
      (strap == TSI_PIN_SCL) ? scl : (strap == TSI_PIN_HIGH)),
      .address_select_pin_0_oe_sda(strap == TSI_PIN_SDA), .address_select_pin_0_oe_scl(strap == TSI_PIN_SCL),
      .address_select_pin_1(pin1), .vsense_raw(vsense), .tdie_raw(tdie), .result_load(result_load),
      .pointer(pointer), .hs_mode(hs_mode), .wr_data(wr_data), .wr_valid(wr_valid), .wr_high(wr_high));
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk_byte(input logic [7:0] x, input logic [7:0] g);
      num_checks++;
      if (g !== x) begin
         fail_count++;
         $display("ERROR %0t exp %h got %h", $time, x, g);
      end
   endtask
   task automatic chk_flag(input logic x, input logic g);
      num_checks++;
      if (g !== x) begin
         fail_count++;
         $display("ERROR %0t exp %h got %h", $time, x, g);
      end
   endtask
   task automatic xfer(input logic [7:0] b, input logic x);
      logic a;
      u_mst.write_byte(b, a);
      chk_flag(x, a);
   endtask
   task automatic rd_word(input logic [15:0] w);
      logic [7:0] b;
      rd_q.push_back(w[15:8]);
      rd_q.push_back(w[7:0]);
      u_mst.read_byte(1'b0, b);
      u_mst.read_byte(1'b1, b);
   endtask
   task automatic sel(input logic [7:0] p);
      u_mst.start();
      xfer(8'h80, 1'b1);
      xfer(p, 1'b1);
   endtask
   task automatic rd_open();
      u_mst.start();
      xfer(8'h81, 1'b1);
   endtask
   task automatic hs_open();
      u_mst.start();
      xfer(8'h08, 1'b0);
      chk_flag(1'b1, hs_mode);
   endtask
   function automatic logic [15:0] clip(input logic signed [23:0] v);
      if (v > 24'sh007FFF) return 16'h7FFF;
      if (v < 24'shFF8000) return 16'h8000;
      return v[15:0];
   endfunction
   always @(negedge clock) begin
      if (rx_stb) begin
         if (rd_q.size() == 0) chk_flag(1'b0, 1'b1);
         else chk_byte(rd_q.pop_front(), rx_byte);
      end
      if (wr_valid === 1'b1) begin
         e = (wr_q.size() == 0) ? 9'h1FF : wr_q.pop_front();
         chk_byte(e[7:0], wr_data);
         chk_flag(e[8], wr_high);
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 90000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      vsense = 24'h000000;
      tdie = 14'h0000;
      result_load = 1'b0;
      strap = TSI_PIN_LOW;
      pin1 = 1'b0;
      repeat (8) @(posedge clock);
      #1;
      resetn = 1'b1;
      repeat (4) @(posedge clock);
      #1;
      chk_byte(8'h00, pointer);
      chk_flag(1'b0, hs_mode);
      chk_flag(1'b0, sda_oe);
      rd_open();
      rd_word(16'h0000);
      u_mst.stop();
      u_mst.half = 30;
      for (int i = 0; i < 4; i++) begin
         vsense = (i < 3) ? vtab[i] : 24'($random(seed));
         tdie = 14'($random(seed));
         result_load = 1'b1;
         @(posedge clock);
         #1;
         result_load = 1'b0;
         hs_open();
         sel(8'h00);
         rd_open();
         rd_word(clip(vsense));
         sel(8'h01);
         wr_q.push_back(9'h1A5);
         wr_q.push_back(9'h03C);
         xfer(8'hA5, 1'b1);
         xfer(8'h3C, 1'b1);
         chk_byte(8'h01, pointer);
         rd_open();
         rd_word({tdie, 2'b00});
         rd_open();
         rd_word({tdie, 2'b00});
         u_mst.stop();
         chk_flag(1'b0, hs_mode);
      end
      // straps change only on an idle bus
      for (int s = 0; s < 8; s++) begin
         pin1 = s[2];
         strap = tsi_strap_t'(s[1:0]);
         hs_open();
         u_mst.start();
         xfer({4'h8, 3'(s + 1), 1'b0}, 1'b0);
         u_mst.start();
         xfer({4'h8, 3'(s), 1'b0}, 1'b1);
         u_mst.stop();
      end
      chk_flag(1'b1, rd_q.size() == 0 && wr_q.size() == 0);
      final_report();
   end
endmodule
